// ### ccdm_pkg.sv
// Purpose: Shared constants for the converter output mode block
// Assumes: One 10 MHz conversion clock domain
// Notes:   Register map, mode bit positions and output codes
package ccdm_pkg;
   // -------------------------------------------------------------
   // Widths and depths
   // -------------------------------------------------------------
   localparam int unsigned CODE_W     = 10;
   localparam int unsigned ADDR_W     = 4;
   localparam int unsigned DATA_W     = 8;
   localparam int unsigned FIFO_DEPTH = 16;
   localparam int unsigned PIPE_DELAY = 5;
   localparam int unsigned SYNC_N     = 4;
   // -------------------------------------------------------------
   // Register offsets
   // -------------------------------------------------------------
   localparam logic [ADDR_W-1:0] REG_MODE     = 4'h0;
   localparam logic [ADDR_W-1:0] REG_STATUS   = 4'h1;
   localparam logic [ADDR_W-1:0] REG_BLACK_LO = 4'h2;
   localparam logic [ADDR_W-1:0] REG_BLACK_HI = 4'h3;
   // -------------------------------------------------------------
   // Mode and status fields
   // -------------------------------------------------------------
   localparam int unsigned MODE_STBY_BIT  = 0;
   localparam int unsigned MODE_TEST_BIT  = 1;
   localparam int unsigned MODE_LOWER_BIT = 2;
   localparam int unsigned MODE_TOP_BIT   = 3;
   localparam int unsigned MODE_POL_BIT   = 4;
   localparam logic [DATA_W-1:0] MODE_RST = 8'h00;
   localparam int unsigned STAT_EMPTY_BIT = 0;
   localparam int unsigned STAT_FULL_BIT  = 1;
   localparam int unsigned STAT_OVF_BIT   = 2;
   localparam int unsigned STAT_CNT_LSB   = 3;
   // -------------------------------------------------------------
   // Pin vector positions
   // -------------------------------------------------------------
   localparam int unsigned PIN_DIS = 0;
   localparam int unsigned PIN_PBL = 1;
   localparam int unsigned PIN_BLK = 2;
   localparam int unsigned PIN_SIG = 3;
   // -------------------------------------------------------------
   // Output codes
   // -------------------------------------------------------------
   localparam logic [CODE_W-1:0] PREBLANK_CODE = 10'h020;
   localparam logic [CODE_W-1:0] TEST_PATTERN  = 10'h155;
   localparam logic [CODE_W-1:0] TOP_MASK      = 10'h200;
   localparam logic [CODE_W-1:0] LOWER_MASK    = 10'h1ff;
   localparam logic [CODE_W-1:0] ZERO_CODE     = 10'h000;
endpackage

// ### ccdm_fifo.sv
// Purpose: Sample FIFO with registered read data
// Assumes: Single clock, synchronous active-high reset
// Notes:   Holds DEPTH words in memory plus one in the output register
`timescale 1ns/1ps
module ccdm_fifo #(
   parameter int unsigned WIDTH = 10,
   parameter int unsigned DEPTH = 16,
   parameter int unsigned CNT_W = $clog2(DEPTH + 2)
) (
   input  wire logic             clk_in,
   input  wire logic             rst_in,
   input  wire logic             in_valid_in,
   output logic                  in_ready_out,
   input  wire logic [WIDTH-1:0] in_data_in,
   output logic                  out_valid_out,
   input  wire logic             out_ready_in,
   output logic      [WIDTH-1:0] out_data_out,
   output logic      [CNT_W-1:0] count_out
);
   localparam int unsigned PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);
   localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [PTR_W-1:0] wr_ptr_reg;
   logic [PTR_W-1:0] rd_ptr_reg;
   logic [CNT_W-1:0] mem_cnt_reg;
   logic             out_valid_reg;
   logic [WIDTH-1:0] out_data_reg;
   logic             push;
   logic             load;

   // -------------------------------------------------------------
   // Handshake
   // -------------------------------------------------------------
   assign in_ready_out  = (mem_cnt_reg != FULL_CNT);
   assign push          = in_valid_in && in_ready_out;
   assign load          = (mem_cnt_reg != '0) && (!out_valid_reg || out_ready_in);
   assign out_valid_out = out_valid_reg;
   assign out_data_out  = out_data_reg;
   assign count_out     = mem_cnt_reg + CNT_W'(out_valid_reg);

   // -------------------------------------------------------------
   // Storage
   // -------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (push) begin
         mem_reg[wr_ptr_reg] <= in_data_in;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         wr_ptr_reg  <= '0;
         rd_ptr_reg  <= '0;
         mem_cnt_reg <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= (wr_ptr_reg == LAST_PTR) ? '0 : wr_ptr_reg + 1'b1;
         end
         if (load) begin
            rd_ptr_reg <= (rd_ptr_reg == LAST_PTR) ? '0 : rd_ptr_reg + 1'b1;
         end
         mem_cnt_reg <= mem_cnt_reg + CNT_W'(push) - CNT_W'(load);
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         out_valid_reg <= 1'b0;
         out_data_reg  <= '0;
      end else if (load) begin
         out_valid_reg <= 1'b1;
         out_data_reg  <= mem_reg[rd_ptr_reg];
      end else if (out_ready_in) begin
         out_valid_reg <= 1'b0;
      end
   end
endmodule

// ### ccdm_top.sv
// Purpose: Sample pulse capture and output mode selection of a CCD converter
// Assumes: ref_clk_in is the 10 MHz conversion clock; pins are asynchronous
// Notes:   Output bus and its enable come from flip-flops
//
// Design decisions made here: the plain strobed port and the address map.
`timescale 1ns/1ps
module ccdm_top
   import ccdm_pkg::*;
(
   input  wire logic              ref_clk_in,
   input  wire logic              rst_in,
   input  wire logic [ADDR_W-1:0] reg_addr_in,
   input  wire logic [DATA_W-1:0] reg_wdata_in,
   input  wire logic              reg_wr_in,
   input  wire logic              reg_rd_in,
   output logic      [DATA_W-1:0] reg_rdata_out,
   input  wire logic [CODE_W-1:0] level_in,
   input  wire logic              out_enable_n_in,
   input  wire logic              preblank_pin_in,
   input  wire logic              black_sample_pulse_in,
   input  wire logic              signal_sample_pulse_in,
   output logic      [CODE_W-1:0] out_data_out,
   output logic                   out_oe_n_out,
   output logic                   capture_ready_out
);
   localparam int unsigned CNT_W    = $clog2(FIFO_DEPTH + 2);
   localparam int unsigned STAGES   = PIPE_DELAY - 3;

   logic [SYNC_N-1:0] ff1_reg;
   logic [SYNC_N-1:0] ff2_reg;
   logic [SYNC_N-1:0] ff3_reg;
   logic [SYNC_N-1:0] stable_reg;
   logic [SYNC_N-1:0] agree;
   logic [DATA_W-1:0] mode_reg;
   logic              overflow_reg;
   logic [DATA_W-1:0] rdata_reg;
   logic [DATA_W-1:0] rdata_next;
   logic              blk_act;
   logic              sig_act;
   logic              blk_prev_reg;
   logic              sig_prev_reg;
   logic              blk_edge;
   logic              sig_edge;
   logic [CODE_W-1:0] black_reg;
   logic [CODE_W-1:0] new_code;
   logic [CODE_W-1:0] cap_code_reg;
   logic              cap_valid_reg;
   logic              fifo_ready;
   logic              fifo_valid;
   logic [CODE_W-1:0] fifo_data;
   logic [CNT_W-1:0]  fifo_count;
   logic              pop;
   logic [STAGES-1:0] d_valid_reg;
   logic [CODE_W-1:0] d_data_reg [STAGES];
   logic [CODE_W-1:0] last_code_reg;
   logic [CODE_W-1:0] code_now;
   logic [CODE_W-1:0] flip_mask;
   logic [CODE_W-1:0] out_data_reg;
   logic              out_oe_n_reg;
   logic              dis;
   logic              pbl;
   logic              stby;
   logic              test;
   logic              pol;

   // -------------------------------------------------------------
   // Pin synchronisers
   // -------------------------------------------------------------
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         ff1_reg <= '0;
         ff2_reg <= '0;
         ff3_reg <= '0;
      end else begin
         ff1_reg <= {signal_sample_pulse_in, black_sample_pulse_in, preblank_pin_in, out_enable_n_in};
         ff2_reg <= ff1_reg;
         ff3_reg <= ff2_reg;
      end
   end

   assign agree = ~(ff2_reg ^ ff3_reg);

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         stable_reg <= '0;
      end else begin
         stable_reg <= (stable_reg & ~agree) | (ff3_reg & agree);
      end
   end

   assign dis  = stable_reg[PIN_DIS];
   assign pbl  = stable_reg[PIN_PBL];
   assign stby = mode_reg[MODE_STBY_BIT];
   assign test = mode_reg[MODE_TEST_BIT];
   assign pol  = mode_reg[MODE_POL_BIT];

   // -------------------------------------------------------------
   // Register port
   // -------------------------------------------------------------
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         mode_reg <= MODE_RST;
      end else if (reg_wr_in && reg_addr_in == REG_MODE) begin
         mode_reg <= reg_wdata_in;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         overflow_reg <= 1'b0;
      end else if (cap_valid_reg && !fifo_ready) begin
         overflow_reg <= 1'b1;
      end else if (reg_wr_in && reg_addr_in == REG_STATUS && reg_wdata_in[STAT_OVF_BIT]) begin
         overflow_reg <= 1'b0;
      end
   end

   always_comb begin
      rdata_next = '0;
      if (reg_rd_in) begin
         unique case (reg_addr_in)
            REG_MODE:     rdata_next = mode_reg;
            REG_STATUS:   rdata_next = {fifo_count, overflow_reg, (fifo_count == CNT_W'(FIFO_DEPTH + 1)),
                                        (fifo_count == '0)};
            REG_BLACK_LO: rdata_next = black_reg[7:0];
            REG_BLACK_HI: rdata_next = {6'h00, black_reg[CODE_W-1:8]};
            default:      rdata_next = '0;
         endcase
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         rdata_reg <= '0;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   assign reg_rdata_out = rdata_reg;

   // -------------------------------------------------------------
   // Sample pulse capture
   // -------------------------------------------------------------
   assign blk_act  = stable_reg[PIN_BLK] ^ pol;
   assign sig_act  = stable_reg[PIN_SIG] ^ pol;
   assign blk_edge = blk_act && !blk_prev_reg;
   assign sig_edge = sig_act && !sig_prev_reg;
   assign new_code = (level_in >= black_reg) ? level_in - black_reg : ZERO_CODE;

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         blk_prev_reg <= 1'b0;
         sig_prev_reg <= 1'b0;
      end else begin
         blk_prev_reg <= blk_act;
         sig_prev_reg <= sig_act;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         black_reg <= '0;
      end else if (blk_edge) begin
         black_reg <= level_in;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         cap_valid_reg <= 1'b0;
         cap_code_reg  <= '0;
      end else begin
         cap_valid_reg <= sig_edge;
         if (sig_edge) begin
            cap_code_reg <= new_code;
         end
      end
   end

   assign capture_ready_out = fifo_ready;

   // -------------------------------------------------------------
   // Sample FIFO and delay line
   // -------------------------------------------------------------
   assign pop = fifo_valid && !stby;

   ccdm_fifo #(
      .WIDTH (CODE_W),
      .DEPTH (FIFO_DEPTH),
      .CNT_W (CNT_W)
   ) u_fifo (
      .clk_in        (ref_clk_in),
      .rst_in        (rst_in),
      .in_valid_in   (cap_valid_reg),
      .in_ready_out  (fifo_ready),
      .in_data_in    (cap_code_reg),
      .out_valid_out (fifo_valid),
      .out_ready_in  (!stby),
      .out_data_out  (fifo_data),
      .count_out     (fifo_count)
   );

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         d_valid_reg <= '0;
      end else begin
         d_valid_reg <= {d_valid_reg[STAGES-2:0], pop};
      end
   end

   always_ff @(posedge ref_clk_in) begin
      d_data_reg[0] <= fifo_data;
      for (int i = 1; i < STAGES; i++) begin
         d_data_reg[i] <= d_data_reg[i-1];
      end
   end

   assign code_now = d_valid_reg[STAGES-1] ? d_data_reg[STAGES-1] : last_code_reg;

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         last_code_reg <= '0;
      end else begin
         last_code_reg <= code_now;
      end
   end

   // -------------------------------------------------------------
   // Output mode selection
   // -------------------------------------------------------------
   assign flip_mask = (mode_reg[MODE_TOP_BIT] ? TOP_MASK : ZERO_CODE) |
                      (mode_reg[MODE_LOWER_BIT] ? LOWER_MASK : ZERO_CODE);

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         out_oe_n_reg <= 1'b1;
         out_data_reg <= '0;
      end else begin
         out_oe_n_reg <= dis || stby;
         if (test) begin
            out_data_reg <= TEST_PATTERN ^ flip_mask;
         end else if (flip_mask != ZERO_CODE) begin
            out_data_reg <= code_now ^ flip_mask;
         end else if (pbl) begin
            out_data_reg <= PREBLANK_CODE;
         end else begin
            out_data_reg <= code_now;
         end
      end
   end

   assign out_data_out = out_data_reg;
   assign out_oe_n_out = out_oe_n_reg;

   // -------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (rst_in);

   logic norm;
   assign norm = !dis && !stby && !test && (flip_mask == ZERO_CODE) && !pbl;

   output_disable_a: assert property (dis |=> out_oe_n_out)
      else $error("disable pin did not float outputs");
   standby_float_a: assert property (!dis && stby |=> out_oe_n_out)
      else $error("standby did not float outputs");
   drive_when_active_a: assert property (!dis && !stby |=> !out_oe_n_out)
      else $error("outputs not driven when enabled");
   preblank_code_a: assert property (!dis && !stby && !test && flip_mask == ZERO_CODE && pbl
                                     |=> out_data_out == 10'h020)
      else $error("pre-blanking code wrong");
   flip_bits_a: assert property (!test && mode_reg[MODE_TOP_BIT] && !mode_reg[MODE_LOWER_BIT]
                                 |=> out_data_out == ($past(code_now) ^ 10'h200))
      else $error("top bit flip wrong");
   test_pattern_a: assert property (test |=> out_data_out == ($past(flip_mask) ^ 10'h155))
      else $error("test pattern wrong");
   mode_write_a: assert property (reg_wr_in && reg_addr_in == REG_MODE
                                  |=> stby == $past(reg_wdata_in[MODE_STBY_BIT]))
      else $error("mode bit not loaded");
   pin_filter_a: assert property ($rose(pbl) |-> $past(ff3_reg[PIN_PBL]) && $past(ff2_reg[PIN_PBL]))
      else $error("pre-blank pin change not filtered");
   polarity_edge_a: assert property (blk_edge && $stable(pol)
                                     |-> $past(stable_reg[PIN_BLK]) == pol && $past(ff3_reg[PIN_BLK]) != pol)
      else $error("black pulse edge wrong polarity");
   black_capture_a: assert property (blk_edge |=> black_reg == $past(level_in))
      else $error("black level not captured");
   latency_a: assert property (sig_edge && fifo_count == '0 && !cap_valid_reg && norm ##1 norm [*5]
                               |=> out_data_out == $past(new_code, 6))
      else $error("code latency wrong");

   preblank_seen_c: cover property (norm ##1 !dis && !stby && pbl && !test);
   test_seen_c:     cover property (test && !dis && !stby ##1 test);
   flip_all_c:      cover property (flip_mask == 10'h3ff && !dis && !stby);
   fifo_full_c:     cover property (!fifo_ready ##1 cap_valid_reg);
endmodule

// ### ccdm_dsp_model.sv
// Purpose: Camera processor model that drives both sample pulses
// Assumes: Pulse levels are held long enough for the pin filter
// Notes:   The idle level of both pulses follows the polarity input
`timescale 1ns/1ps
module ccdm_dsp_model (
   input  wire logic ref_clk_in,
   input  wire logic polarity_in,
   output logic      black_pulse_out,
   output logic      signal_pulse_out
);
   // ---------------------------------------------------------------
   // Pulse generation
   // ---------------------------------------------------------------
   logic black_act = 1'b0;
   logic signal_act = 1'b0;

   assign black_pulse_out  = black_act ^ polarity_in;
   assign signal_pulse_out = signal_act ^ polarity_in;

   // One pulse: rises within a clock period, held 4 cycles, low 4 cycles
   task automatic pulse(input bit is_signal);
      @(posedge ref_clk_in);
      #25;
      if (is_signal) begin
         #20;
         signal_act = 1'b1;
      end else begin
         black_act = 1'b1;
      end
      repeat (4) @(posedge ref_clk_in);
      #25;
      black_act  = 1'b0;
      signal_act = 1'b0;
      repeat (4) @(posedge ref_clk_in);
   endtask
endmodule

// ### testbench.sv
// Purpose: Self-checking bench for the converter output mode block
// Assumes: Seeded random modes and levels, corner cases first
// Notes:   Outputs are compared once pins and pipeline have settled
`timescale 1ns/1ps
module testbench
   import ccdm_pkg::*;
;
   // ---------------------------------------------------------------
   // Signals
   // ---------------------------------------------------------------
   logic              clk     = 1'b0;
   logic              rst     = 1'b1;
   logic [ADDR_W-1:0] addr    = '0;
   logic [DATA_W-1:0] wdata   = '0;
   logic              wr      = 1'b0;
   logic              rd      = 1'b0;
   logic [DATA_W-1:0] rdata;
   logic [CODE_W-1:0] level   = '0;
   logic              dis     = 1'b0;
   logic              pre     = 1'b0;
   logic              pol     = 1'b0;
   logic              blk_p;
   logic              sig_p;
   logic [CODE_W-1:0] dout;
   logic              doe_n;
   logic              cap_rdy;
   int                n_mismatch  = 0;
   int                checks_done = 0;

   always #50 clk = ~clk;

   ccdm_top u_ccdm_top (
      .ref_clk_in             (clk),
      .rst_in                 (rst),
      .reg_addr_in            (addr),
      .reg_wdata_in           (wdata),
      .reg_wr_in              (wr),
      .reg_rd_in              (rd),
      .reg_rdata_out          (rdata),
      .level_in               (level),
      .out_enable_n_in        (dis),
      .preblank_pin_in        (pre),
      .black_sample_pulse_in  (blk_p),
      .signal_sample_pulse_in (sig_p),
      .out_data_out           (dout),
      .out_oe_n_out           (doe_n),
      .capture_ready_out      (cap_rdy)
   );

   ccdm_dsp_model u_ccdm_dsp_model (
      .ref_clk_in       (clk),
      .polarity_in      (pol),
      .black_pulse_out  (blk_p),
      .signal_pulse_out (sig_p)
   );

   // ---------------------------------------------------------------
   // Compare, bus and expectation helpers
   // ---------------------------------------------------------------
   task automatic check_reg(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: read %h, expected %h", $time, got, exp);
      end
   endtask

   task automatic check_out(input logic exp_oe_n, input logic [9:0] exp);
      checks_done++;
      if (doe_n !== exp_oe_n || (exp_oe_n === 1'b0 && dout !== exp)) begin
         n_mismatch++;
         $display("unexpected at %0t: output %b/%h, expected %b/%h", $time, doe_n, dout, exp_oe_n, exp);
      end
   endtask

   task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
   endtask

   task automatic reg_read(input logic [3:0] a, input logic [7:0] exp);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      #1;
      check_reg(rdata, exp);
   endtask

   task automatic take_sample(input logic [9:0] blk, input logic [9:0] sig);
      @(posedge clk);
      level <= blk;
      u_ccdm_dsp_model.pulse(1'b0);
      level <= sig;
      u_ccdm_dsp_model.pulse(1'b1);
   endtask

   function automatic logic [9:0] exp_data(input logic [7:0] m, input logic pb, input logic [9:0] c);
      logic [9:0] mask;
      mask = (m[MODE_TOP_BIT] ? 10'h200 : 10'h000) | (m[MODE_LOWER_BIT] ? 10'h1ff : 10'h000);
      if (m[MODE_TEST_BIT]) return 10'h155 ^ mask;
      if (mask != 10'h000) return c ^ mask;
      if (pb) return 10'h020;
      return c;
   endfunction

   task automatic report_and_stop();
      $display("checks_done %0d, n_mismatch %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      logic [7:0] mode;
      logic [9:0] blk;
      logic [9:0] sig;
      logic [9:0] code;
      logic       d;
      logic       p;
      void'($urandom(93501));
      code = 10'h000;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      reg_read(REG_MODE, 8'h00);
      reg_read(REG_STATUS, 8'h01);
      reg_write(4'hf, 8'hff);
      reg_read(4'hf, 8'h00);
      for (int i = 0; i < 56; i++) begin
         blk  = 10'($urandom);
         sig  = 10'($urandom);
         mode = 8'($urandom) & 8'h0f;
         d    = ($urandom % 4) == 0;
         p    = 1'($urandom);
         if (i < 16) begin
            mode = {4'h0, 3'(i), 1'b0};
            d    = 1'b0;
            p    = i[3];
         end
         if (i == 0) {blk, sig} = {10'h000, 10'h3ff};
         if (i == 1) {blk, sig} = {10'h000, 10'h000};
         if (i == 2) {blk, sig} = {10'h12c, 10'h064};
         reg_write(REG_MODE, mode);
         dis <= d;
         pre <= p;
         if (!mode[MODE_STBY_BIT]) begin
            take_sample(blk, sig);
            code = (sig > blk) ? sig - blk : 10'h000;
         end
         repeat (10) @(posedge clk);
         #1;
         check_out(d | mode[MODE_STBY_BIT], exp_data(mode, p, code));
      end
      reg_write(REG_MODE, 8'h00);
      dis <= 1'b0;
      pre <= 1'b0;
      take_sample(10'h2a5, 10'h3ff);
      repeat (10) @(posedge clk);
      #1;
      check_out(1'b0, 10'h15a);
      reg_read(REG_BLACK_LO, 8'ha5);
      reg_write(REG_BLACK_HI, 8'hff);
      reg_read(REG_BLACK_HI, 8'h02);
      reg_write(REG_MODE, 8'h10);
      pol <= 1'b1;
      repeat (20) @(posedge clk);
      take_sample(10'h010, 10'h123);
      repeat (10) @(posedge clk);
      #1;
      check_out(1'b0, 10'h113);
      reg_write(REG_MODE, 8'h00);
      pol <= 1'b0;
      repeat (20) @(posedge clk);
      reg_write(REG_MODE, 8'h01);
      for (int j = 0; j < 18; j++) take_sample(10'h005, 10'h045 + 10'(j));
      #1;
      check_out(1'b1, 10'h000);
      check_reg({7'h00, cap_rdy}, 8'h00);
      reg_read(REG_STATUS, 8'h8e);
      reg_write(REG_STATUS, 8'h04);
      reg_read(REG_STATUS, 8'h8a);
      reg_write(REG_MODE, 8'h00);
      repeat (60) @(posedge clk);
      reg_read(REG_STATUS, 8'h01);
      check_out(1'b0, 10'h050);
      report_and_stop();
   end

   // ---------------------------------------------------------------
   // Watchdog
   // ---------------------------------------------------------------
   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      report_and_stop();
   end
endmodule
